// ### hdl/cfr_cfg.svh
/*
  Constants of the CPU flag register block: bus offsets, field positions,
  reset values and widths.
  Assumes inclusion by bare name from the package, ahead of the design modules.
*/
`ifndef CFR_CFG_SVH
`define CFR_CFG_SVH

// ----------------------------------------
// Register bus offsets (byte addresses)
// ----------------------------------------
`define CFR_OFS_FLAG      4'h0
`define CFR_OFS_ACTIVE_SP 4'h4
`define CFR_OFS_LAST_IRQ  4'h8

// ----------------------------------------
// Field positions inside the flag register
// ----------------------------------------
`define CFR_POS_CARRY     0
`define CFR_POS_DEBUG     1
`define CFR_POS_ZERO      2
`define CFR_POS_SIGN      3
`define CFR_POS_BANK      4
`define CFR_POS_OVERFLOW  5
`define CFR_POS_IRQ_EN    6
`define CFR_POS_STACK     7
`define CFR_POS_PRIO_LO   8
`define CFR_POS_PRIO_HI   10
`define CFR_POS_RESERVED  11

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define CFR_FLAG_W        11
`define CFR_PRIO_W        3
`define CFR_FLAG_RST      11'h000
`define CFR_SP_RST        16'h0000
`define CFR_TRAP_HW_MAX   6'h1F
`define CFR_ALU_EN_W      4

`endif

// ### hdl/cfr_pkg.sv
/*
  Types shared by the CPU flag register block.
  Assumes cfr_cfg.svh is on the include path.
*/
`include "cfr_cfg.svh"

package cfr_pkg;

  // ----------------------------------------
  // Flag register layout, MSB first
  // ----------------------------------------
  typedef struct packed {
    logic [`CFR_PRIO_W-1:0] prio;
    logic                   stack_sel;
    logic                   irq_en;
    logic                   overflow;
    logic                   bank_sel;
    logic                   sign;
    logic                   zero;
    logic                   debug;
    logic                   carry;
  } cfr_flags_type;

  // ----------------------------------------
  // Which ALU flags an operation touches
  // ----------------------------------------
  typedef struct packed {
    logic overflow;
    logic sign;
    logic zero;
    logic carry;
  } cfr_alu_en_type;

  typedef logic [2:0] cfr_reg_idx_type;

endpackage

// ### hdl/cfr_bank_if.sv
/*
  Carrier between flag register control and the register bank store.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps

interface cfr_bank_if;
  import cfr_pkg::*;

  logic            bank_sel;
  logic            stack_sel;
  logic            reg_we;
  cfr_reg_idx_type reg_idx;
  logic [15:0]     reg_wdata;
  logic [15:0]     reg_rdata;
  logic            sp_we;
  logic [15:0]     sp_wdata;
  logic [15:0]     sp_rdata;

  modport ctrl (
    output bank_sel,
    output stack_sel,
    output reg_we,
    output reg_idx,
    output reg_wdata,
    output sp_we,
    output sp_wdata,
    input  reg_rdata,
    input  sp_rdata
  );

  modport store (
    input  bank_sel,
    input  stack_sel,
    input  reg_we,
    input  reg_idx,
    input  reg_wdata,
    input  sp_we,
    input  sp_wdata,
    output reg_rdata,
    output sp_rdata
  );
endinterface

// ### hdl/cfr_bank.sv
/*
  Two register banks of seven 16-bit registers and the two stack pointers.
  Assumes bank and stack selects come from the flag register on the same clock.
*/
`timescale 1ns/1ps

module cfr_bank
  import cfr_pkg::*;
#(
  parameter int NUM_REGS = 7
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Control side
  cfr_bank_if.store bus
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] gpr_mem [0:1][0:NUM_REGS-1];
  logic [15:0] exc_sp_reg;
  logic [15:0] exc_sp_next;
  logic [15:0] user_sp_reg;
  logic [15:0] user_sp_next;
  logic [15:0] reg_rdata_reg;
  logic [15:0] reg_rdata_next;
  logic [15:0] sp_rdata_reg;
  logic [15:0] sp_rdata_next;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    exc_sp_next    = exc_sp_reg;
    user_sp_next   = user_sp_reg;
    reg_rdata_next = 16'h0000;
    if (bus.sp_we) begin
      if (bus.stack_sel) begin
        user_sp_next = bus.sp_wdata;
      end else begin
        exc_sp_next = bus.sp_wdata;
      end
    end
    sp_rdata_next = bus.stack_sel ? user_sp_next : exc_sp_next;
    if (int'(bus.reg_idx) < NUM_REGS) begin
      reg_rdata_next = gpr_mem[bus.bank_sel][bus.reg_idx];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      exc_sp_reg    <= `CFR_SP_RST;
      user_sp_reg   <= `CFR_SP_RST;
      reg_rdata_reg <= 16'h0000;
      sp_rdata_reg  <= `CFR_SP_RST;
      for (int b = 0; b < 2; b++) begin
        for (int r = 0; r < NUM_REGS; r++) begin
          gpr_mem[b][r] <= 16'h0000;
        end
      end
    end else begin
      exc_sp_reg    <= exc_sp_next;
      user_sp_reg   <= user_sp_next;
      reg_rdata_reg <= reg_rdata_next;
      sp_rdata_reg  <= sp_rdata_next;
      // Only the selected bank is written; the other keeps its contents
      if (bus.reg_we && int'(bus.reg_idx) < NUM_REGS) begin
        gpr_mem[bus.bank_sel][bus.reg_idx] <= bus.reg_wdata;
      end
    end
  end

  assign bus.reg_rdata = reg_rdata_reg;
  assign bus.sp_rdata  = sp_rdata_reg;

endmodule

// ### hdl/cfr_flag_reg.sv
/*
  CPU flag register with ALU flag capture, interrupt acceptance, software
  trap handling and the register bank / stack pointer selection it drives.
  Assumes one clock, a synchronous reset and an Avalon-MM master that holds
  each request until it sees waitrequest low.
*/
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module cfr_flag_reg
  import cfr_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  // Avalon-MM slave
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // ALU result
  input  wire logic                     alu_valid,
  input  wire cfr_alu_en_type           alu_flag_en,
  input  wire logic [DATA_W-1:0]        alu_result,
  input  wire logic                     alu_carry,
  input  wire logic                     alu_overflow,
  // Interrupt request
  input  wire logic                     irq_req,
  input  wire logic                     irq_maskable,
  input  wire logic [`CFR_PRIO_W-1:0]   irq_level,
  output logic                          irq_accept,
  // Software trap
  input  wire logic                     trap_exec,
  input  wire logic [5:0]               trap_num,
  // Register bank access
  input  wire logic                     core_reg_we,
  input  wire cfr_reg_idx_type          core_reg_idx,
  input  wire logic [15:0]              core_reg_wdata,
  output logic      [15:0]              core_reg_rdata,
  input  wire logic                     core_sp_we,
  input  wire logic [15:0]              core_sp_wdata,
  output logic      [15:0]              core_sp_rdata,
  // Flag state
  output cfr_flags_type                 flags
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  cfr_flags_type                 flag_reg;
  cfr_flags_type                 flag_next;
  logic                          irq_accept_reg;
  logic                          irq_accept_next;
  logic [`CFR_PRIO_W-1:0]        last_level_reg;
  logic [`CFR_PRIO_W-1:0]        last_level_next;
  logic                          waitreq_reg;
  logic                          waitreq_next;
  logic [31:0]                   rdata_reg;
  logic [31:0]                   rdata_next;

  logic                          bus_req;
  logic                          bus_done;
  logic                          irq_take;
  logic                          trap_hw_range;
  logic [`CFR_FLAG_W-1:0]        flag_bits;
  logic [`CFR_FLAG_W-1:0]        flag_wr_bits;
  logic [31:0]                   flag_word;
  logic [31:0]                   sp_word;
  logic [31:0]                   level_word;
  logic                          flag_wr_sel;
  logic                          lane0_wr;
  logic                          lane1_wr;
  logic                          alu_is_zero;
  logic                          alu_is_neg;
  logic                          upd_carry;
  logic                          upd_zero;
  logic                          upd_sign;
  logic                          upd_ovf;
  logic                          irq_en_clr;
  logic                          stack_clr;

  cfr_bank_if bank_bus ();

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle per access: the read word is latched in the cycle
  // before waitrequest drops, so it stands at the completing edge.
  assign bus_req  = avs_read | avs_write;
  assign bus_done = bus_req & ~waitreq_reg;

  always_comb begin
    waitreq_next = ~(bus_req & waitreq_reg);
  end

  // ----------------------------------------
  // Bus handshake register
  // ----------------------------------------
  // Starts high so no request completes on the edge that ends reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= waitreq_next;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Reserved bit above the field reads as zero
  assign flag_word  = {21'h000000, flag_reg};
  assign sp_word    = {16'h0000, bank_bus.sp_rdata};
  assign level_word = {29'h00000000, last_level_reg};

  always_comb begin
    rdata_next = rdata_reg;
    if (avs_read && waitreq_reg) begin
      case (avs_address)
        `CFR_OFS_FLAG: begin
          rdata_next = flag_word;
        end
        `CFR_OFS_ACTIVE_SP: begin
          rdata_next = sp_word;
        end
        `CFR_OFS_LAST_IRQ: begin
          rdata_next = level_word;
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Interrupt acceptance
  // ----------------------------------------
  always_comb begin
    irq_take = 1'b0;
    if (irq_req && (irq_level > flag_reg.prio)) begin
      irq_take = ~irq_maskable | flag_reg.irq_en;
    end
    irq_accept_next = irq_take;
    last_level_next = irq_take ? irq_level : last_level_reg;
  end

  // ----------------------------------------
  // Interrupt registers
  // ----------------------------------------
  // One pulse per accepting edge; a held request pulses again while allowed
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_accept_reg <= 1'b0;
      last_level_reg <= '0;
    end else begin
      irq_accept_reg <= irq_accept_next;
      last_level_reg <= last_level_next;
    end
  end

  // Traps need no priority check
  assign trap_hw_range = (trap_num <= `CFR_TRAP_HW_MAX);

  // ----------------------------------------
  // Update decode
  // ----------------------------------------
  // Only the completing edge of a bus write reaches the flags
  assign flag_wr_sel = avs_write && bus_done && (avs_address == `CFR_OFS_FLAG);
  // Lanes 2 and 3 carry no flag bits and are ignored
  assign lane0_wr    = flag_wr_sel && avs_byteenable[0];
  assign lane1_wr    = flag_wr_sel && avs_byteenable[1];
  assign alu_is_zero = (alu_result == '0);
  assign alu_is_neg  = alu_result[DATA_W-1];
  // Flags an operation does not name keep their value
  assign upd_carry   = alu_valid && alu_flag_en.carry;
  assign upd_zero    = alu_valid && alu_flag_en.zero;
  assign upd_sign    = alu_valid && alu_flag_en.sign;
  assign upd_ovf     = alu_valid && alu_flag_en.overflow;
  assign irq_en_clr  = irq_take || trap_exec;
  assign stack_clr   = irq_take || (trap_exec && trap_hw_range);

  // ----------------------------------------
  // Flag register update
  // ----------------------------------------
  // Order: bus write, then ALU, then acceptance clears, so a hardware
  // event in the same cycle as a software write is never lost.
  assign flag_bits = flag_reg;

  always_comb begin
    flag_wr_bits = flag_bits;
    if (lane0_wr) begin
      // Debug bit is stored as written; software keeps it at zero
      flag_wr_bits[`CFR_POS_STACK:`CFR_POS_CARRY] = avs_writedata[7:0];
    end
    if (lane1_wr) begin
      // Reserved bit 11 is dropped on write
      flag_wr_bits[`CFR_POS_PRIO_HI:`CFR_POS_PRIO_LO] =
        avs_writedata[`CFR_POS_PRIO_HI:`CFR_POS_PRIO_LO];
    end
    flag_next = cfr_flags_type'(flag_wr_bits);
    if (upd_carry) begin
      flag_next.carry = alu_carry;
    end
    if (upd_zero) begin
      flag_next.zero = alu_is_zero;
    end
    if (upd_sign) begin
      flag_next.sign = alu_is_neg;
    end
    if (upd_ovf) begin
      flag_next.overflow = alu_overflow;
    end
    if (irq_en_clr) begin
      flag_next.irq_en = 1'b0;
    end
    if (stack_clr) begin
      flag_next.stack_sel = 1'b0;
    end
  end

  // ----------------------------------------
  // Flag register
  // ----------------------------------------
  // Priority is left alone on acceptance; software raises it itself
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_reg <= cfr_flags_type'(`CFR_FLAG_RST);
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------
  // Register banks and stack pointers
  // ----------------------------------------
  // Selects follow the stored flags, so a select change takes effect
  // for accesses one cycle after the flag edge.
  assign bank_bus.bank_sel  = flag_reg.bank_sel;
  assign bank_bus.stack_sel = flag_reg.stack_sel;
  assign bank_bus.reg_we    = core_reg_we;
  assign bank_bus.reg_idx   = core_reg_idx;
  assign bank_bus.reg_wdata = core_reg_wdata;
  assign bank_bus.sp_we     = core_sp_we;
  assign bank_bus.sp_wdata  = core_sp_wdata;

  cfr_bank #(
    .NUM_REGS (7)
  ) u_bank (
    .clk_sys (clk_sys),
    .srst    (srst),
    .bus     (bank_bus.store)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign irq_accept      = irq_accept_reg;
  assign core_reg_rdata  = bank_bus.reg_rdata;
  assign core_sp_rdata   = bank_bus.sp_rdata;
  assign flags           = flag_reg;

endmodule

// ### verif/cfr_flag_reg_sva.sv
/*
  Concurrent checks on the ports of the CPU flag register top module.
  Assumes one clock and a synchronous active-high reset, bound below.
*/
`timescale 1ns/1ps

module cfr_flag_reg_sva
  import cfr_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              srst,
  // Bus
  input wire logic [3:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // Core side
  input wire logic              alu_valid,
  input wire cfr_alu_en_type    alu_flag_en,
  input wire logic [DATA_W-1:0] alu_result,
  input wire logic              alu_carry,
  input wire logic              alu_overflow,
  input wire logic              irq_req,
  input wire logic              irq_maskable,
  input wire logic [2:0]        irq_level,
  input wire logic              irq_accept,
  input wire logic              trap_exec,
  input wire logic [5:0]        trap_num,
  input wire cfr_flags_type     flags
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Acceptance condition, used both ways so a flipped compare is caught
  logic take;
  assign take = irq_req && (irq_level > flags.prio) && (!irq_maskable || flags.irq_en);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_reset;
    $fell(srst) |-> flags == 11'h000 && !irq_accept && avs_waitrequest;
  endproperty
  a_reset: assert property (p_reset) else $error("flags not cleared by reset");
  property p_accept;
    take |=> irq_accept && !flags.irq_en && !flags.stack_sel;
  endproperty
  a_accept: assert property (p_accept) else $error("irq not taken");
  property p_refuse;
    !take |=> !irq_accept;
  endproperty
  a_refuse: assert property (p_refuse) else $error("irq taken wrongly");
  property p_carry;
    alu_valid && alu_flag_en.carry |=> flags.carry == $past(alu_carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_zero;
    alu_valid && alu_flag_en.zero |=> flags.zero == ($past(alu_result) == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero wrong");
  property p_sign;
    alu_valid && alu_flag_en.sign |=> flags.sign == $past(alu_result[DATA_W-1]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign wrong");
  property p_ovf;
    alu_valid && alu_flag_en.overflow |=> flags.overflow == $past(alu_overflow);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_keep;
    !(alu_valid && alu_flag_en.carry) && !(avs_write && !avs_waitrequest) |=> $stable(flags.carry);
  endproperty
  a_keep: assert property (p_keep) else $error("carry changed untouched");
  property p_trap;
    trap_exec |=> !flags.irq_en;
  endproperty
  a_trap: assert property (p_trap) else $error("trap left irq enabled");
  property p_trap_stk;
    trap_exec && trap_num <= 6'h1F |=> !flags.stack_sel;
  endproperty
  a_trap_stk: assert property (p_trap_stk) else $error("trap kept stack select");
  property p_bus;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("wait cycle wrong");
  property p_rd;
    avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata == {21'h0, $past(flags)};
  endproperty
  a_rd: assert property (p_rd) else $error("flag read wrong");

  c_accept: cover property (take ##1 irq_accept);
  c_trap: cover property (trap_exec && trap_num > 6'h1F);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind cfr_flag_reg cfr_flag_reg_sva #(.DATA_W(DATA_W)) chk_u (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .alu_valid(alu_valid), .alu_flag_en(alu_flag_en), .alu_result(alu_result),
  .alu_carry(alu_carry), .alu_overflow(alu_overflow), .irq_req(irq_req),
  .irq_maskable(irq_maskable), .irq_level(irq_level), .irq_accept(irq_accept),
  .trap_exec(trap_exec), .trap_num(trap_num), .flags(flags)
);

// ### verif/cfr_flag_reg_tb.sv
/*
  Self-checking bench for the CPU flag register block.
  Assumes design files and the checker are compiled first.
*/
`timescale 1ns/1ps

module cfr_flag_reg_tb
  import cfr_pkg::*;
;
  logic            clk_sys = 1'b0;
  logic            srst = 1'b1;
  logic [3:0]      avs_address = 4'h0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = 32'h0;
  logic [3:0]      avs_byteenable = 4'hF;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic            alu_valid = 1'b0;
  cfr_alu_en_type  alu_flag_en = 4'h0;
  logic [15:0]     alu_result = 16'h0;
  logic            alu_carry = 1'b0;
  logic            alu_overflow = 1'b0;
  logic            irq_req = 1'b0;
  logic            irq_maskable = 1'b0;
  logic [2:0]      irq_level = 3'h0;
  logic            irq_accept;
  logic            trap_exec = 1'b0;
  logic [5:0]      trap_num = 6'h0;
  logic            core_reg_we = 1'b0;
  cfr_reg_idx_type core_reg_idx = 3'h0;
  logic [15:0]     core_reg_wdata = 16'h0;
  logic [15:0]     core_reg_rdata;
  logic            core_sp_we = 1'b0;
  logic [15:0]     core_sp_wdata = 16'h0;
  logic [15:0]     core_sp_rdata;
  cfr_flags_type   flags;
  cfr_flags_type   exp_f;
  logic [31:0]     rd;
  int              failures = 0;
  int              tests_run = 0;
  // Tables: ALU enables/results, irq {level, maskable, accepted}
  logic [3:0]      en_t [3] = '{4'hF, 4'hF, 4'h1};
  logic [15:0]     res_t [3] = '{16'h0000, 16'h8000, 16'h0000};
  logic [2:0]      c_t = 3'b101;
  logic [2:0]      o_t = 3'b010;
  logic [4:0]      irq_t [5] = '{5'h0E, 5'h13, 5'h1E, 5'h1D, 5'h08};

  cfr_flag_reg dut_u (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alu_valid(alu_valid),
    .alu_flag_en(alu_flag_en), .alu_result(alu_result), .alu_carry(alu_carry),
    .alu_overflow(alu_overflow), .irq_req(irq_req), .irq_maskable(irq_maskable),
    .irq_level(irq_level), .irq_accept(irq_accept), .trap_exec(trap_exec),
    .trap_num(trap_num), .core_reg_we(core_reg_we), .core_reg_idx(core_reg_idx),
    .core_reg_wdata(core_reg_wdata), .core_reg_rdata(core_reg_rdata),
    .core_sp_we(core_sp_we), .core_sp_wdata(core_sp_wdata),
    .core_sp_rdata(core_sp_rdata), .flags(flags)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flags();
    check({21'h0, flags}, {21'h0, exp_f});
  endtask

  // Holds the request until waitrequest is sampled low, giving up and ending the test after 20 cycles
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      test_done();
    end
    #1;
  endtask

  task automatic wf(input logic [10:0] v);
    bus(1'b1, 4'h0, {21'h0, v}, 4'hF);
    exp_f = cfr_flags_type'(v);
  endtask

  // Ends a one-cycle strobe and lets its edge land
  task automatic fin();
    @(posedge clk_sys);
    alu_valid <= 1'b0;
    irq_req <= 1'b0;
    trap_exec <= 1'b0;
    core_reg_we <= 1'b0;
    core_sp_we <= 1'b0;
    #1;
  endtask

  task automatic reg_op(input logic we, input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk_sys);
    core_reg_we <= we;
    core_reg_idx <= idx;
    core_reg_wdata <= d;
    fin();
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    exp_f = '0;
    check_flags();
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h0);
    wf(11'h7FD);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h7FD);
    bus(1'b1, 4'h0, 32'h0, 4'h2);
    exp_f.prio = 3'h0;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h0FD);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    check(rd, 32'h0);
    check_flags();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      alu_valid <= 1'b1;
      alu_flag_en <= en_t[i];
      alu_result <= res_t[i];
      alu_carry <= c_t[i];
      alu_overflow <= o_t[i];
      fin();
      if (en_t[i][0]) exp_f.carry = c_t[i];
      if (en_t[i][1]) exp_f.zero = (res_t[i] == 16'h0);
      if (en_t[i][2]) exp_f.sign = res_t[i][15];
      if (en_t[i][3]) exp_f.overflow = o_t[i];
      check_flags();
    end
    wf(11'h3C0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      irq_req <= 1'b1;
      irq_level <= irq_t[i][4:2];
      irq_maskable <= irq_t[i][1];
      fin();
      check({31'h0, irq_accept}, {31'h0, irq_t[i][0]});
      if (irq_t[i][0]) exp_f.irq_en = 1'b0;
      if (irq_t[i][0]) exp_f.stack_sel = 1'b0;
      check_flags();
    end
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    check(rd, 32'h7);
    for (int i = 0; i < 2; i++) begin
      wf(11'h0C0);
      @(posedge clk_sys);
      trap_exec <= 1'b1;
      trap_num <= 6'h20 - 6'(i);
      fin();
      exp_f.irq_en = 1'b0;
      exp_f.stack_sel = (i == 0);
      check_flags();
    end
    for (int i = 0; i < 2; i++) begin
      wf(i ? 11'h080 : 11'h000);
      @(posedge clk_sys);
      core_sp_we <= 1'b1;
      core_sp_wdata <= i ? 16'h5678 : 16'h1234;
      fin();
      check({16'h0, core_sp_rdata}, i ? 32'h5678 : 32'h1234);
    end
    wf(11'h000);
    @(posedge clk_sys);
    #1;
    check({16'h0, core_sp_rdata}, 32'h1234);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    check(rd, 32'h1234);
    // Banks written first, read after, so a shared store shows up
    for (int b = 0; b < 2; b++) begin
      wf(b ? 11'h010 : 11'h000);
      for (int r = 0; r < 7; r++) reg_op(1'b1, 3'(r), 16'hA000 + 16'(b * 256 + r));
    end
    for (int b = 0; b < 2; b++) begin
      wf(b ? 11'h010 : 11'h000);
      for (int r = 0; r < 7; r++) begin
        reg_op(1'b0, 3'(r), 16'h0);
        check({16'h0, core_reg_rdata}, 32'hA000 + 32'(b * 256 + r));
      end
    end
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    #1;
    exp_f = '0;
    check_flags();
    @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    test_done();
  end
endmodule
